// *** ucf_map.vh ***
// Constants for one UART channel with hardware flow control.
// Assumes an 8-bit host data port and a 16x sample enable from outside.
`ifndef UCF_MAP_VH
`define UCF_MAP_VH
// Data port: channel N sits at N * stride, low nibble zero
`define UCF_CH_STRIDE 6'h10
`define UCF_DATA_OFS 4'h0
// Sample ticks per bit and to mid start bit
`define UCF_BIT_TICKS 4'hf
`define UCF_HALF_TICKS 4'h7
// Timeout: 4 words plus 12 bits, in bits
`define UCF_TO_WORDS 6'h04
`define UCF_TO_EXTRA 6'h0c
// Line control fields
`define UCF_LCR_WL 1:0
`define UCF_LCR_STOP2 2
`define UCF_LCR_PAREN 3
`define UCF_LCR_EVEN 4
// Modem control fields
`define UCF_MCR_DTR 0
`define UCF_MCR_RTS 1
`define UCF_MCR_SEL 2
// Enhanced feature fields
`define UCF_EFR_IEREN 4
`define UCF_EFR_ARTS 6
`define UCF_EFR_ACTS 7
// Interrupt enable fields
`define UCF_IER_RX 0
`define UCF_IER_TX 1
`define UCF_IER_REQ 6
`define UCF_IER_CLR 7
// Line status fields
`define UCF_LSR_DR 0
`define UCF_LSR_OE 1
`define UCF_LSR_ERR 4:2
`define UCF_LSR_THRE 5
`define UCF_LSR_TEMT 6
// Reset values
`define UCF_LSR_RST 8'h60
`define UCF_IERHI_RST 2'h0
`endif

// *** ucf_channel.v ***
// One UART channel: transmit and receive paths, FIFOs, status, auto flow.
// Assumes a 16x sample enable pulse from an outside divider and host
// strobes synchronous to clk_sys. Control registers arrive as plain inputs.
//
// Contract
// (R01) Each transmitted bit lasts 16 sample ticks.
// (R02) Frame: start, data LSB first, optional parity, stop bit(s).
// (R03) In FIFO mode each data port write pushes one byte into 64-byte FIFO.
// (R04) Non-FIFO: holding-empty flag sets when byte moves to shift register.
// (R05) Non-FIFO: holding-empty raises transmit interrupt only if enabled.
// (R06) Transmitter-empty flag: shift register idle and transmit FIFO empty.
// (R07) FIFO mode: holding-empty flag set whenever transmit FIFO is empty.
// (R08) FIFO mode: transmit interrupt when fill below trigger and enabled.
// (R09) Start bit: falling edge, sample 8 ticks later, accept if low.
// (R10) Data and stop bits sampled mid-bit, same method.
// (R11) Receive FIFO 64 entries of 8 data plus 3 error tags.
// (R12) Host read pops FIFO and updates error status to next entry.
// (R13) Receive-ready interrupt per character or at trigger, if enabled.
// (R14) Timeout interrupt after 4 words plus 12 bits with data unread.
// (R15) Data port at channel offset; write loads, read unloads.
// (R16) Pair select, auto receive and auto transmit flow enables.
// (R17) Software starts auto flow by setting the selected request bit.
// (R18) Tables A-C: request high at next level up, low at next down.
// (R19) Table D: high at trigger plus hysteresis, low below minus.
// (R20) Receiver keeps storing until FIFO full despite request high.
// (R21) Clear input high stops transmit after current stop bit.
// (R22) Flow interrupt on request or clear transitions, enables gated.
// (R23) While suspended, transmit FIFO keeps bytes and accepts writes.
`timescale 1ns/100ps
`include "ucf_map.vh"

////////////////////////////////////////////////////////////////////////////
module ucf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Mode: one entry only when low
  input wire deepMode,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  output wire [AW:0] count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire [AW:0] limit = deepMode ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1};
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  assign inReady = count_r < limit;
  assign outValid = count_r != {(AW+1){1'b0}};
  assign outData = mem[rdPtr_r];
  assign count = count_r;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      case ({push, pop})
        2'b10: count_r <= count_r + 1'b1;
        2'b01: count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end
endmodule // ucf_fifo

////////////////////////////////////////////////////////////////////////////
module ucf_channel #(
  parameter [1:0] CHANNEL = 2'h0
) (
  // Clock, reset, 16x sample enable
  input wire clk_sys,
  input wire resetn,
  input wire sampleTick,
  // Host data port
  input wire [5:0] hostAddr,
  input wire hostWr,
  input wire hostRd,
  input wire [7:0] hostWdata,
  output reg [7:0] hostRdata_r,
  output reg txReady_r,
  // Control register contents
  input wire fifoEnable,
  input wire [4:0] lineCtl,
  input wire [2:0] modemCtl,
  input wire [7:0] enhFeature,
  input wire [7:0] intEnable,
  input wire [3:0] hystLevel,
  input wire trigTableD,
  input wire [6:0] txTrig,
  input wire [6:0] rxTrig,
  input wire [6:0] rxTrigUp,
  input wire [6:0] rxTrigDown,
  input wire flowIrqClear,
  // Status
  output reg [7:0] lineStatus_r,
  output reg rxReadyIrq_r,
  output reg txEmptyIrq_r,
  output reg rxTimeoutIrq_r,
  output reg flowIrq_r,
  // Serial and modem pins
  output reg txd_r,
  input wire rxd,
  output reg rtsN_r,
  output reg dtrN_r,
  input wire ctsN,
  input wire dsrN
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_DATA = 5'h04;
  localparam [4:0] S_PAR = 5'h08;
  localparam [4:0] S_STOP = 5'h10;

  // Parity over the active data bits; odd parity inverts it
  function parBit;
    input [7:0] d;
    input [1:0] wl;
    input even;
    reg [7:0] m;
    begin
      m = 8'hff >> (2'h3 - wl);
      parBit = ^(d & m) ^ ~even;
    end
  endfunction

  wire [2:0] lastBit = {1'b1, lineCtl[`UCF_LCR_WL]};
  wire [3:0] nBits = {2'h0, lineCtl[`UCF_LCR_WL]} + 4'h5;

  //////////////////////////////////////////////////////////////////////////
  // Host port decode
  wire portHit = hostAddr == {CHANNEL, `UCF_DATA_OFS}; // (R15)
  wire hostWrHit = hostWr & portHit;
  wire hostRdHit = hostRd & portHit;

  //////////////////////////////////////////////////////////////////////////
  // Transmit FIFO
  wire txInReady;
  wire txValid;
  wire [7:0] txHead;
  wire [6:0] txCount;
  wire txLoad;

  ucf_fifo #(.WIDTH(8), .DEPTH(64), .AW(6)) txFifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .deepMode(fifoEnable),
    .inValid(hostWrHit), // (R03) (R23)
    .inReady(txInReady),
    .inData(hostWdata),
    .outValid(txValid),
    .outReady(txLoad),
    .outData(txHead),
    .count(txCount)
  );

  //////////////////////////////////////////////////////////////////////////
  // Flow control pin selection
  wire useDtr = modemCtl[`UCF_MCR_SEL]; // (R16)
  wire reqBit = useDtr ? modemCtl[`UCF_MCR_DTR] : modemCtl[`UCF_MCR_RTS];
  wire clrHigh = useDtr ? dsrN : ctsN;
  wire autoRx = enhFeature[`UCF_EFR_ARTS] & reqBit; // (R17)
  wire txHold = enhFeature[`UCF_EFR_ACTS] & clrHigh; // (R21)

  //////////////////////////////////////////////////////////////////////////
  // Transmitter
  reg [4:0] txState_r;
  reg [7:0] txShift_r;
  reg [3:0] txTick_r;
  reg [2:0] txBit_r;
  reg txPar_r;
  wire txBitEnd = sampleTick && txTick_r == `UCF_BIT_TICKS; // (R01)

  // Next frame waits in idle while the far end holds us off
  assign txLoad = txState_r[0] & txValid & ~txHold; // (R21) (R23)

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txState_r <= S_IDLE;
      txShift_r <= 8'h00;
      txTick_r <= 4'h0;
      txBit_r <= 3'h0;
      txPar_r <= 1'b0;
      txd_r <= 1'b1;
    end else begin
      if (sampleTick && !txState_r[0]) begin
        txTick_r <= txTick_r + 1'b1;
      end
      case (txState_r)
        S_IDLE: begin
          txd_r <= 1'b1;
          txTick_r <= 4'h0;
          if (txLoad) begin
            txShift_r <= txHead;
            txPar_r <= parBit(txHead, lineCtl[`UCF_LCR_WL], lineCtl[`UCF_LCR_EVEN]);
            txBit_r <= 3'h0;
            txd_r <= 1'b0; // (R02)
            txState_r <= S_START;
          end
        end
        S_START: begin
          if (txBitEnd) begin
            txd_r <= txShift_r[0]; // (R02)
            txState_r <= S_DATA;
          end
        end
        S_DATA: begin
          if (txBitEnd) begin
            txShift_r <= {1'b0, txShift_r[7:1]};
            txBit_r <= txBit_r + 1'b1;
            if (txBit_r == lastBit) begin
              txBit_r <= 3'h0;
              txd_r <= lineCtl[`UCF_LCR_PAREN] ? txPar_r : 1'b1;
              txState_r <= lineCtl[`UCF_LCR_PAREN] ? S_PAR : S_STOP;
            end else begin
              txd_r <= txShift_r[1];
            end
          end
        end
        S_PAR: begin
          if (txBitEnd) begin
            txd_r <= 1'b1;
            txState_r <= S_STOP;
          end
        end
        S_STOP: begin
          if (txBitEnd) begin
            txBit_r <= 3'h1;
            if (txBit_r[0] || !lineCtl[`UCF_LCR_STOP2]) begin
              txState_r <= S_IDLE;
            end
          end
        end
        default: txState_r <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver
  reg [4:0] rxState_r;
  reg [7:0] rxShift_r;
  reg [3:0] rxTick_r;
  reg [2:0] rxBit_r;
  reg rxPrev_r;
  reg rxParErr_r;
  reg rxPush_r;
  reg [10:0] rxEntry_r;
  reg overrun_r;
  wire rxInReady;
  wire rxValid;
  wire [10:0] rxHead;
  wire [6:0] rxCount;
  wire rxFall = rxPrev_r & ~rxd; // (R09)
  wire rxMid = sampleTick && rxTick_r == `UCF_BIT_TICKS; // (R10)
  wire rxHalf = sampleTick && rxTick_r == `UCF_HALF_TICKS; // (R09)
  wire [7:0] rxAligned = rxShift_r >> (2'h3 - lineCtl[`UCF_LCR_WL]);
  wire rxParOne = lineCtl[`UCF_LCR_PAREN] & (rxParErr_r ^ ~lineCtl[`UCF_LCR_EVEN]);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxState_r <= S_IDLE;
      rxShift_r <= 8'h00;
      rxTick_r <= 4'h0;
      rxBit_r <= 3'h0;
      rxPrev_r <= 1'b1;
      rxParErr_r <= 1'b0;
      rxPush_r <= 1'b0;
      rxEntry_r <= 11'h000;
    end else begin
      rxPrev_r <= rxd;
      rxPush_r <= 1'b0;
      if (sampleTick) begin
        rxTick_r <= rxTick_r + 1'b1;
      end
      case (rxState_r)
        S_IDLE: begin
          rxTick_r <= 4'h0;
          if (rxFall) begin
            rxState_r <= S_START;
          end
        end
        S_START: begin
          if (rxHalf) begin
            rxTick_r <= 4'h0;
            rxBit_r <= 3'h0;
            rxParErr_r <= 1'b0;
            rxState_r <= rxd ? S_IDLE : S_DATA; // (R09)
          end
        end
        S_DATA: begin
          if (rxMid) begin
            rxShift_r <= {rxd, rxShift_r[7:1]}; // (R10)
            rxBit_r <= rxBit_r + 1'b1;
            if (rxBit_r == lastBit) begin
              rxState_r <= lineCtl[`UCF_LCR_PAREN] ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (rxMid) begin
            rxParErr_r <= rxd ^ parBit(rxAligned, lineCtl[`UCF_LCR_WL], lineCtl[`UCF_LCR_EVEN]);
            rxState_r <= S_STOP;
          end
        end
        S_STOP: begin
          if (rxMid) begin
            // Break: data, parity and stop low; with zero data the parity bit equals its error flag, inverted for odd parity
            rxEntry_r <= {~rxd & ~|rxAligned & ~rxParOne, ~rxd, rxParErr_r, rxAligned}; // (R11)
            rxPush_r <= 1'b1; // (R20)
            rxState_r <= S_IDLE;
          end
        end
        default: rxState_r <= S_IDLE;
      endcase
    end
  end

  // Entries keep their three tags so the status follows the head byte
  ucf_fifo #(.WIDTH(11), .DEPTH(64), .AW(6)) rxFifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .deepMode(fifoEnable),
    .inValid(rxPush_r), // (R11) (R20)
    .inReady(rxInReady),
    .inData(rxEntry_r),
    .outValid(rxValid),
    .outReady(hostRdHit), // (R12)
    .outData(rxHead),
    .count(rxCount)
  );

  //////////////////////////////////////////////////////////////////////////
  // Receive timeout, counted in sample ticks
  reg [9:0] toCnt_r;
  reg toFlag_r;
  wire [9:0] toLimit = {({2'h0, nBits} * `UCF_TO_WORDS + `UCF_TO_EXTRA), 4'h0};

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      toCnt_r <= 10'h000;
      toFlag_r <= 1'b0;
    end else begin
      if (rxPush_r || hostRdHit || !rxValid) begin
        toCnt_r <= 10'h000;
        toFlag_r <= 1'b0;
      end else if (sampleTick && !toFlag_r) begin
        toCnt_r <= toCnt_r + 1'b1;
        if (toCnt_r + 1'b1 == toLimit) begin
          toFlag_r <= 1'b1; // (R14)
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Automatic request output with hysteresis
  reg reqHigh_r;
  reg [1:0] ierHi_r;
  reg reqPrev_r;
  reg clrPrev_r;
  wire [7:0] rxFill = {1'b0, rxCount};
  wire [7:0] hiLvl = trigTableD ? {1'b0, rxTrig} + {4'h0, hystLevel} : {1'b0, rxTrigUp};
  wire [7:0] loLvl = trigTableD ? {1'b0, rxTrig} - {4'h0, hystLevel} : {1'b0, rxTrigDown} + 8'h01;
  wire reqPin = autoRx ? reqHigh_r : ~reqBit;
  wire reqEdge = reqPin ^ reqPrev_r;
  wire clrEdge = clrHigh ^ clrPrev_r;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reqHigh_r <= 1'b0;
      ierHi_r <= `UCF_IERHI_RST;
      reqPrev_r <= 1'b1;
      clrPrev_r <= 1'b1;
      flowIrq_r <= 1'b0;
      rtsN_r <= 1'b1;
      dtrN_r <= 1'b1;
    end else begin
      if (!autoRx) begin
        reqHigh_r <= 1'b0;
      end else if (rxFill >= hiLvl) begin
        reqHigh_r <= 1'b1; // (R18) (R19)
      end else if (rxFill < loLvl) begin
        reqHigh_r <= 1'b0; // (R18) (R19)
      end
      if (enhFeature[`UCF_EFR_IEREN]) begin
        ierHi_r <= {intEnable[`UCF_IER_CLR], intEnable[`UCF_IER_REQ]}; // (R22)
      end
      reqPrev_r <= reqPin;
      clrPrev_r <= clrHigh;
      // A new edge wins over a clear in the same cycle
      if ((reqEdge & ierHi_r[0]) | (clrEdge & ierHi_r[1])) begin
        flowIrq_r <= 1'b1; // (R22)
      end else if (flowIrqClear) begin
        flowIrq_r <= 1'b0;
      end
      rtsN_r <= useDtr ? ~modemCtl[`UCF_MCR_RTS] : reqPin; // (R16)
      dtrN_r <= useDtr ? reqPin : ~modemCtl[`UCF_MCR_DTR];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status, interrupts and read data
  wire thrEmpty = ~txValid; // (R04) (R07)
  wire txIdle = txState_r[0] & thrEmpty; // (R06)
  wire txIrq = fifoEnable ? ({1'b0, txCount} < {1'b0, txTrig}) : thrEmpty; // (R05) (R08)
  wire rxIrq = fifoEnable ? ({1'b0, rxCount} >= {1'b0, rxTrig}) & rxValid : rxValid; // (R13)

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hostRdata_r <= 8'h00;
      txReady_r <= 1'b0;
      overrun_r <= 1'b0;
      lineStatus_r <= `UCF_LSR_RST;
      rxReadyIrq_r <= 1'b0;
      txEmptyIrq_r <= 1'b0;
      rxTimeoutIrq_r <= 1'b0;
    end else begin
      txReady_r <= txInReady;
      if (hostRdHit) begin
        hostRdata_r <= rxHead[7:0]; // (R15)
      end
      // Character lost when no room is left; new loss beats the read clear
      if (rxPush_r && !rxInReady) begin
        overrun_r <= 1'b1;
      end else if (hostRdHit) begin
        overrun_r <= 1'b0;
      end
      lineStatus_r <= 8'h00;
      lineStatus_r[`UCF_LSR_DR] <= rxValid;
      lineStatus_r[`UCF_LSR_OE] <= overrun_r;
      lineStatus_r[`UCF_LSR_ERR] <= rxValid ? rxHead[10:8] : 3'h0; // (R12)
      lineStatus_r[`UCF_LSR_THRE] <= thrEmpty; // (R04) (R07)
      lineStatus_r[`UCF_LSR_TEMT] <= txIdle; // (R06)
      txEmptyIrq_r <= txIrq & intEnable[`UCF_IER_TX]; // (R05) (R08)
      rxReadyIrq_r <= rxIrq & intEnable[`UCF_IER_RX]; // (R13)
      rxTimeoutIrq_r <= toFlag_r & intEnable[`UCF_IER_RX]; // (R14)
    end
  end
endmodule // ucf_channel

// *** ucf_remote_uart.sv ***
// Remote UART model: 8N1 receiver on the channel's serial output and sender into its input.
// Assumes the bench supplies clk_sys and the 16x sample tick.
`timescale 1ns/100ps
module ucf_remote_uart (
  // Clock and 16x tick
  input wire logic clk_sys,
  input wire logic sampleTick,
  // Serial lines and clear input
  input wire logic txd,
  output logic rxd,
  output logic ctsN
);
  logic [7:0] gotQ[$];
  logic [7:0] rxByte;
  int stopBad = 0;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rxd = 1'b1;
    ctsN = 1'b0;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys iff sampleTick);
  endtask
  // Mid-bit sampling tolerates the load-to-tick skew of the start bit
  initial forever begin
    @(negedge txd);
    ticks(8);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        ticks(16);
        rxByte[i] = txd;
      end
      ticks(16);
      if (txd !== 1'b1) stopBad++;
      gotQ.push_back(rxByte);
    end
  end
  // Line idles high after the stop bit, as a marking line does
  task automatic sendByte(input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    ticks(1);
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      ticks(16);
    end
  endtask
  task automatic hold(input logic b);
    @(posedge clk_sys);
    ctsN <= b;
  endtask
endmodule // ucf_remote_uart

// *** ucf_channel_chk.sv ***
// Checker for one UART channel: bit timing, status flags, flow control pins.
// Assumes it is bound to ucf_channel and sees only its ports.
`timescale 1ns/100ps
module ucf_channel_chk #(
  parameter [1:0] CHANNEL = 2'h0
) (
  // Clock, reset, tick
  input wire clk_sys,
  input wire resetn,
  input wire sampleTick,
  // Host and control
  input wire [5:0] hostAddr,
  input wire hostWr,
  input wire [2:0] modemCtl,
  input wire [7:0] enhFeature,
  input wire [7:0] intEnable,
  input wire ctsN,
  // Outputs
  input wire [7:0] lineStatus_r,
  input wire rxReadyIrq_r,
  input wire txEmptyIrq_r,
  input wire txd_r,
  input wire rtsN_r,
  input wire dtrN_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  reg txdQ_r;
  reg [4:0] bitCnt_r;
  wire hit = hostAddr == {CHANNEL, 4'h0};
  wire ctsHold = enhFeature[7] && !modemCtl[2] && ctsN;
  // Ticks since txd last moved; saturation marks an idle line
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txdQ_r <= 1'b1;
      bitCnt_r <= 5'h1f;
    end else begin
      txdQ_r <= txd_r;
      if (txd_r != txdQ_r) bitCnt_r <= 5'h0;
      else if (sampleTick && bitCnt_r != 5'h1f) bitCnt_r <= bitCnt_r + 5'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Six cycles leave room for a synchroniser on the clear input
  sequence s_cts_held;
    ctsHold [*6];
  endsequence
  chk_bit_time: assert property ($changed(txd_r) |-> bitCnt_r >= 5'h0f)
    else $error("serial bit shorter than 16 ticks");
  chk_hold_start: assert property (s_cts_held |=> !($fell(txd_r) && bitCnt_r == 5'h1f))
    else $error("frame started while held off");
  chk_tx_irq: assert property (!intEnable[1] [*2] |-> !txEmptyIrq_r)
    else $error("transmit interrupt while disabled");
  chk_rx_irq: assert property (!intEnable[0] [*2] |-> !rxReadyIrq_r)
    else $error("receive interrupt while disabled");
  chk_empty_pair: assert property (lineStatus_r[6] |-> lineStatus_r[5])
    else $error("transmitter empty without holding empty");
  chk_rts_level: assert property ((!enhFeature[6] && !modemCtl[2] && modemCtl[1]) [*3] |-> !rtsN_r)
    else $error("request pin does not follow its bit");
  chk_dtr_level: assert property ((!enhFeature[6] && modemCtl[2] && modemCtl[0]) [*3] |-> !dtrN_r)
    else $error("ready pin does not follow its bit");
  chk_miss_write: assert property (hostWr && !hit && lineStatus_r[6] && !$past(hostWr) |=> lineStatus_r[6])
    else $error("write to other channel was taken");
  chk_hit_write: assert property (hostWr && hit && lineStatus_r[6] |-> ##[1:3] !lineStatus_r[6])
    else $error("write to data port not taken");
endmodule // ucf_channel_chk

bind ucf_channel ucf_channel_chk #(.CHANNEL(CHANNEL)) ucf_channel_chk_inst (.clk_sys, .resetn, .sampleTick,
  .hostAddr, .hostWr, .modemCtl, .enhFeature, .intEnable, .ctsN, .lineStatus_r, .rxReadyIrq_r,
  .txEmptyIrq_r, .txd_r, .rtsN_r, .dtrN_r);

// *** tb_uart_channel_txrx_flow_ctl.sv ***
// Testbench for one UART channel with hardware flow control.
// Assumes the remote UART model and the bound checker are compiled first.
`timescale 1ns/100ps
module tb_uart_channel_txrx_flow_ctl;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic sampleTick = 1'b0;
  logic [5:0] hostAddr = 6'h0;
  logic hostWr = 1'b0;
  logic hostRd = 1'b0;
  logic [7:0] hostWdata = 8'h0;
  logic fifoEnable = 1'b1;
  logic [4:0] lineCtl = 5'h03;
  logic [2:0] modemCtl = 3'h0;
  logic [7:0] enhFeature = 8'h0;
  logic [7:0] intEnable = 8'h0;
  logic [6:0] rxTrig = 7'h1;
  logic [6:0] rxTrigUp = 7'h2;
  logic [6:0] rxTrigDown = 7'h1;
  logic [3:0] hystLevel = 4'h0;
  logic trigTableD = 1'b0;
  logic [6:0] txTrig = 7'h1;
  logic flowIrqClear = 1'b0;
  logic dsrN = 1'b1;
  wire [7:0] hostRdata_r, lineStatus_r;
  wire txReady_r, rxReadyIrq_r, txEmptyIrq_r, rxTimeoutIrq_r, flowIrq_r, txd_r, rxd, rtsN_r, dtrN_r, ctsN;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] rdByte;
  always #2 clk_sys = ~clk_sys;
  // Tick every other cycle keeps frames short while mid-bit stays clear
  always @(posedge clk_sys) sampleTick <= ~sampleTick;
  ucf_channel ucf_channel_inst (.clk_sys, .resetn, .sampleTick, .hostAddr, .hostWr, .hostRd, .hostWdata,
    .hostRdata_r, .txReady_r, .fifoEnable, .lineCtl, .modemCtl, .enhFeature, .intEnable, .hystLevel,
    .trigTableD, .txTrig, .rxTrig, .rxTrigUp, .rxTrigDown, .flowIrqClear, .lineStatus_r,
    .rxReadyIrq_r, .txEmptyIrq_r, .rxTimeoutIrq_r, .flowIrq_r, .txd_r, .rxd, .rtsN_r, .dtrN_r, .ctsN,
    .dsrN);
  ucf_remote_uart ucf_remote_uart_inst (.clk_sys, .sampleTick, .txd(txd_r), .rxd, .ctsN);
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hostAddr <= a;
    hostWdata <= d;
    hostWr <= 1'b1;
    @(posedge clk_sys);
    hostWr <= 1'b0;
  endtask
  task automatic rd(output logic [7:0] d);
    @(posedge clk_sys);
    hostAddr <= 6'h0;
    hostRd <= 1'b1;
    @(posedge clk_sys);
    hostRd <= 1'b0;
    cycles(1);
    d = hostRdata_r;
  endtask
  task automatic waitRx(input int n);
    for (int k = 0; k < 30000 && ucf_remote_uart_inst.gotQ.size() < n; k++) @(posedge clk_sys);
    cycles(700);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_tx_flow;
    check("lineStatus", lineStatus_r, 8'h60);
    check("txd idle", 8'(txd_r), 8'h1);
    wr(6'h10, 8'h5a);
    cycles(400);
    check("other channel frames", 8'(ucf_remote_uart_inst.gotQ.size()), 8'h0);
    @(posedge clk_sys);
    enhFeature <= 8'h80;
    modemCtl <= 3'h2;
    intEnable <= 8'h02;
    txTrig <= 7'h40;
    ucf_remote_uart_inst.hold(1'b1);
    cycles(8);
    for (int i = 0; i < 65; i++) wr(6'h0, 8'(i));
    cycles(4);
    check("txReady full", 8'(txReady_r), 8'h0);
    check("holding empty", 8'(lineStatus_r[5]), 8'h0);
    check("held frames", 8'(ucf_remote_uart_inst.gotQ.size()), 8'h0);
    check("tx irq at full", 8'(txEmptyIrq_r), 8'h0);
    ucf_remote_uart_inst.hold(1'b0);
    waitRx(64);
    check("frames sent", 8'(ucf_remote_uart_inst.gotQ.size()), 8'd64);
    check("first byte", ucf_remote_uart_inst.gotQ[0], 8'h00);
    check("last byte", ucf_remote_uart_inst.gotQ[63], 8'h3f);
    check("stop errors", 8'(ucf_remote_uart_inst.stopBad), 8'h0);
    check("empty flags", 8'(lineStatus_r[6:5]), 8'h3);
    check("tx irq below trigger", 8'(txEmptyIrq_r), 8'h1);
    ucf_remote_uart_inst.gotQ.delete();
    $display("transmit and clear hold done");
  endtask
  task automatic test_rx_rts;
    @(posedge clk_sys);
    enhFeature <= 8'h50;
    intEnable <= 8'h41;
    cycles(4);
    check("request before fill", 8'(rtsN_r), 8'h0);
    ucf_remote_uart_inst.sendByte(8'ha5);
    ucf_remote_uart_inst.sendByte(8'h3c);
    cycles(40);
    check("request at upper level", 8'(rtsN_r), 8'h1);
    check("flow interrupt", 8'(flowIrq_r), 8'h1);
    @(posedge clk_sys);
    flowIrqClear <= 1'b1;
    @(posedge clk_sys);
    flowIrqClear <= 1'b0;
    cycles(1);
    check("flow irq cleared", 8'(flowIrq_r), 8'h0);
    check("rx ready irq", 8'(rxReadyIrq_r), 8'h1);
    check("rx status", 8'(lineStatus_r[4:0]), 8'h1);
    ucf_remote_uart_inst.sendByte(8'hc3);
    cycles(40);
    rd(rdByte);
    check("read 1", rdByte, 8'ha5);
    rd(rdByte);
    check("read 2", rdByte, 8'h3c);
    cycles(4);
    check("request at lower level", 8'(rtsN_r), 8'h0);
    check("flow irq on release", 8'(flowIrq_r), 8'h1);
    rd(rdByte);
    check("read 3", rdByte, 8'hc3);
    cycles(3);
    check("data ready clear", 8'(lineStatus_r[0]), 8'h0);
    $display("receive and request pin done");
  endtask
  task automatic test_timeout;
    @(posedge clk_sys);
    enhFeature <= 8'h0;
    intEnable <= 8'h01;
    rxTrig <= 7'h8;
    rxTrigUp <= 7'h10;
    ucf_remote_uart_inst.sendByte(8'h96);
    cycles(40);
    check("below trigger irq", 8'(rxReadyIrq_r), 8'h0);
    check("early timeout", 8'(rxTimeoutIrq_r), 8'h0);
    cycles(1450);
    check("timeout irq", 8'(rxTimeoutIrq_r), 8'h1);
    rd(rdByte);
    check("timeout byte", rdByte, 8'h96);
    $display("receive timeout done");
  endtask
  task automatic test_non_fifo;
    @(posedge clk_sys);
    fifoEnable <= 1'b0;
    intEnable <= 8'h02;
    modemCtl <= 3'h5;
    enhFeature <= 8'h80;
    dsrN <= 1'b0;
    ucf_remote_uart_inst.hold(1'b1);
    cycles(4);
    check("ready pin", 8'(dtrN_r), 8'h0);
    wr(6'h0, 8'h81);
    cycles(4);
    check("moved to shifter", 8'(lineStatus_r[6:5]), 8'h1);
    check("tx empty irq", 8'(txEmptyIrq_r), 8'h1);
    @(posedge clk_sys);
    intEnable <= 8'h00;
    cycles(3);
    check("tx irq masked", 8'(txEmptyIrq_r), 8'h0);
    waitRx(1);
    check("single byte", ucf_remote_uart_inst.gotQ[0], 8'h81);
    $display("single holding register done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    cycles(2);
    test_tx_flow;
    test_rx_rts;
    test_timeout;
    test_non_fifo;
    complete_run;
  end
  // Whole run is near 26000 cycles; over twice that means a hang
  initial begin
    #(4 * 60000);
    err_count++;
    $display("BAD watchdog expected done seen hang");
    complete_run;
  end
endmodule // tb_uart_channel_txrx_flow_ctl
